/* File: hw/hsfc_pkg.sv */
// Constants for the host serial flow control block.
// Assumes a single 20 MHz core clock; all users qualify names with hsfc_pkg::.
package hsfc_pkg;

	// ==========================================================
	// Clock and serial timing
	localparam int CLK_HZ = 20_000_000;
	localparam int OVS = 16;
	localparam int BAUD_RATE [7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};

	// ==========================================================
	// Register indices
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_START = 4'h1;
	localparam logic [3:0] A_STOP = 4'h2;
	localparam logic [3:0] A_XON = 4'h3;
	localparam logic [3:0] A_XOFF = 4'h4;
	localparam logic [3:0] A_BAUD = 4'h5;
	localparam logic [3:0] A_FAXRATE = 4'h6;
	localparam logic [3:0] A_LEVEL = 4'h7;
	localparam logic [3:0] A_FAXTHR = 4'h8;
	localparam logic [3:0] A_STATUS = 4'h9;

	// ==========================================================
	// Control field positions
	localparam int B_SWFLOW = 0;
	localparam int B_TRANS = 1;
	localparam int B_TRFLOW = 2;
	localparam int B_TXFLOW = 3;
	localparam int B_PERMIT = 4;
	localparam int B_XKF = 5;
	localparam int B_CHKSUM = 6;
	localparam int B_POLLED = 7;
	localparam int B_FAX = 8;
	localparam int B_EXTRST = 9;
	localparam int CTRL_W = 10;

	// ==========================================================
	// Values after reset and drive level limits
	localparam logic [9:0] CTRL_RST = 10'h011;
	localparam logic [7:0] START_RST = 8'h11;
	localparam logic [7:0] STOP_RST = 8'h13;
	localparam logic [7:0] XON_RST = 8'h11;
	localparam logic [7:0] XOFF_RST = 8'h13;
	localparam logic [2:0] BAUD_RST = 3'h5;
	localparam logic [15:0] FAXRATE_RST = 16'h0078;
	localparam logic [7:0] FAXTHR_RST = 8'h80;
	localparam logic [8:0] LEVEL_RST = 9'h064;
	localparam logic [8:0] LEVEL_MAX = 9'h1F6;
	localparam logic [8:0] LEVEL_FINE_MAX = 9'h0FF;

	// ==========================================================
	// Serial engine states
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_START = 2'b01,
		SER_DATA = 2'b10,
		SER_STOP = 2'b11
	} hsfc_ser_t;

endpackage : hsfc_pkg

/* File: hw/hsfc_top.sv */
// Host serial port logic: 8N1 link, flow control, status lines, fax bits.
// Assumes host pins are already synchronous to core_clk and that the core
// side presents bytes with valid/ready and a level asking to stop input.
`timescale 1ns/10ps
`default_nettype none

// Operation
// [RULE_01] Software flow: send pause/resume, obey stop/start
// [RULE_02] Conventional characters: start/resume 11, stop/pause 13
// [RULE_03] Software flow off: only handshake lines count
// [RULE_04] Any zero flow character disables software flow
// [RULE_05] Send pause character when input must stop
// [RULE_06] Send resume character when input may restart
// [RULE_07] Transparent mode consults receive/transmit flow settings
// [RULE_08] Transmit permit off inhibits radio keying only
// [RULE_09] Send to host only while RTS grants
// [RULE_10] CTS tells host to stop or resume
// [RULE_11] DSR high while powered
// [RULE_12] DCD follows connection of current stream
// [RULE_13] DTR input is ignored
// [RULE_14] Fax mode streams thresholded samples as bits
// [RULE_15] Checksum setting only with extended keyed framing
// [RULE_16] Polled setting only with extended keyed framing
// [RULE_17] Drive code 0..502, default 100, coarse above 255
// [RULE_18] External pin pulled low causes soft reset
// [RULE_19] Link is 8N1 at 300 to 19200 baud
// [RULE_20] Transparent without transmit flow throttles by CTS
// [RULE_21] Halt after at most the current character
// [RULE_22] Fax sampling instants from evenly spaced divider
module hsfc_top #(
	parameter int CLK_HZ = hsfc_pkg::CLK_HZ
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic host_txd,
	output logic host_rxd,
	input wire logic host_rts,
	output logic host_cts,
	output logic host_dsr,
	output logic host_dcd,
	input wire logic host_dtr,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_throttle,
	input wire logic link_connected,
	input wire logic [7:0] audio_sample,
	input wire logic radio_key_req,
	output logic radio_key,
	output logic [8:0] drive_level_code,
	output logic drive_coarse,
	output logic xkf_checksum_on,
	output logic xkf_polled_on,
	input wire logic external_input_pin,
	output logic soft_reset
);

	// ==========================================================
	// Reset release and external reset pin
	logic [1:0] rst_pipe_reg;
	logic rst_sync_n;
	logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
	logic [hsfc_pkg::CTRL_W-1:0] ctrl_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rst_pipe_reg <= 2'h0;
		else
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe_reg[1];

	// Pin is mechanical; the second and third stages feed the edge detector
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ext_s1_reg <= 1'b1;
			ext_s2_reg <= 1'b1;
			ext_s3_reg <= 1'b1;
			soft_reset <= 1'b0;
		end else begin
			ext_s1_reg <= external_input_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
			soft_reset <= ctrl_reg[hsfc_pkg::B_EXTRST] && ext_s3_reg &&
				!ext_s2_reg; // RULE_18
		end
	end

	// ==========================================================
	// Register file
	logic [7:0] start_chr_reg, stop_chr_reg, xon_chr_reg, xoff_chr_reg;
	logic [7:0] fax_thr_reg;
	logic [2:0] baud_sel_reg;
	logic [15:0] fax_rate_reg;
	logic [7:0] status;
	logic halt_sw_reg, paused_reg;
	logic sw_active, recog_en, send_en;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_reg <= hsfc_pkg::CTRL_RST;
			start_chr_reg <= hsfc_pkg::START_RST; // RULE_02
			stop_chr_reg <= hsfc_pkg::STOP_RST;
			xon_chr_reg <= hsfc_pkg::XON_RST;
			xoff_chr_reg <= hsfc_pkg::XOFF_RST;
			baud_sel_reg <= hsfc_pkg::BAUD_RST;
			fax_rate_reg <= hsfc_pkg::FAXRATE_RST;
			fax_thr_reg <= hsfc_pkg::FAXTHR_RST;
			drive_level_code <= hsfc_pkg::LEVEL_RST;
			drive_coarse <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				hsfc_pkg::A_CTRL: ctrl_reg <= reg_wdata[hsfc_pkg::CTRL_W-1:0];
				hsfc_pkg::A_START: start_chr_reg <= reg_wdata[7:0];
				hsfc_pkg::A_STOP: stop_chr_reg <= reg_wdata[7:0];
				hsfc_pkg::A_XON: xon_chr_reg <= reg_wdata[7:0];
				hsfc_pkg::A_XOFF: xoff_chr_reg <= reg_wdata[7:0];
				hsfc_pkg::A_BAUD: begin
					// Codes past the fastest rate fall back to it
					if (reg_wdata[2:0] > 3'h6)
						baud_sel_reg <= 3'h6;
					else
						baud_sel_reg <= reg_wdata[2:0]; // RULE_19
				end
				hsfc_pkg::A_FAXRATE: fax_rate_reg <= reg_wdata;
				hsfc_pkg::A_FAXTHR: fax_thr_reg <= reg_wdata[7:0];
				hsfc_pkg::A_LEVEL: begin
					if (reg_wdata > 16'(hsfc_pkg::LEVEL_MAX)) begin
						drive_level_code <= hsfc_pkg::LEVEL_MAX; // RULE_17
						drive_coarse <= 1'b1;
					end else begin
						drive_level_code <= reg_wdata[8:0];
						drive_coarse <= reg_wdata[8:0] > hsfc_pkg::LEVEL_FINE_MAX;
					end
				end
				default: ;
			endcase
		end
	end

	// The host DTR level is left out of status on purpose // RULE_13
	assign status = {recog_en, send_en, sw_active, paused_reg, host_dcd,
		host_cts, host_rts, halt_sw_reg};

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				hsfc_pkg::A_CTRL: reg_rdata <= 16'(ctrl_reg);
				hsfc_pkg::A_START: reg_rdata <= {8'h00, start_chr_reg};
				hsfc_pkg::A_STOP: reg_rdata <= {8'h00, stop_chr_reg};
				hsfc_pkg::A_XON: reg_rdata <= {8'h00, xon_chr_reg};
				hsfc_pkg::A_XOFF: reg_rdata <= {8'h00, xoff_chr_reg};
				hsfc_pkg::A_BAUD: reg_rdata <= {13'h0000, baud_sel_reg};
				hsfc_pkg::A_FAXRATE: reg_rdata <= fax_rate_reg;
				hsfc_pkg::A_FAXTHR: reg_rdata <= {8'h00, fax_thr_reg};
				hsfc_pkg::A_LEVEL: reg_rdata <= {7'h00, drive_level_code};
				hsfc_pkg::A_STATUS: reg_rdata <= {8'h00, status};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ==========================================================
	// Flow mode decode
	always_comb begin
		sw_active = ctrl_reg[hsfc_pkg::B_SWFLOW] && start_chr_reg != 8'h00 &&
			stop_chr_reg != 8'h00 && xon_chr_reg != 8'h00 &&
			xoff_chr_reg != 8'h00; // RULE_04
		recog_en = sw_active && !(ctrl_reg[hsfc_pkg::B_TRANS] &&
			ctrl_reg[hsfc_pkg::B_TRFLOW]); // RULE_07
		send_en = sw_active && (!ctrl_reg[hsfc_pkg::B_TRANS] ||
			ctrl_reg[hsfc_pkg::B_TXFLOW]); // RULE_20
	end

	// ==========================================================
	// Oversampling tick, sixteen per bit
	function automatic logic [12:0] baud_div(input logic [2:0] sel);
		case (sel)
			3'h0: baud_div = 13'(CLK_HZ / (hsfc_pkg::OVS * hsfc_pkg::BAUD_RATE[0]) - 1);
			3'h1: baud_div = 13'(CLK_HZ / (hsfc_pkg::OVS * hsfc_pkg::BAUD_RATE[1]) - 1);
			3'h2: baud_div = 13'(CLK_HZ / (hsfc_pkg::OVS * hsfc_pkg::BAUD_RATE[2]) - 1);
			3'h3: baud_div = 13'(CLK_HZ / (hsfc_pkg::OVS * hsfc_pkg::BAUD_RATE[3]) - 1);
			3'h4: baud_div = 13'(CLK_HZ / (hsfc_pkg::OVS * hsfc_pkg::BAUD_RATE[4]) - 1);
			3'h5: baud_div = 13'(CLK_HZ / (hsfc_pkg::OVS * hsfc_pkg::BAUD_RATE[5]) - 1);
			default: baud_div = 13'(CLK_HZ / (hsfc_pkg::OVS * hsfc_pkg::BAUD_RATE[6]) - 1);
		endcase
	endfunction : baud_div

	logic [12:0] baud_cnt_reg;
	logic ovs_tick_reg;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			baud_cnt_reg <= 13'h0000;
			ovs_tick_reg <= 1'b0;
		end else if (baud_cnt_reg == 13'h0000) begin
			baud_cnt_reg <= baud_div(baud_sel_reg); // RULE_19
			ovs_tick_reg <= 1'b1;
		end else begin
			baud_cnt_reg <= baud_cnt_reg - 13'h0001;
			ovs_tick_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Receiver from host, 8N1, sampled mid-bit
	hsfc_pkg::hsfc_ser_t rxs_reg;
	logic [3:0] rx_ovs_reg;
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_sh_reg;
	logic rx_done_reg, is_stop, is_start;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rxs_reg <= hsfc_pkg::SER_IDLE;
			rx_ovs_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_sh_reg <= 8'h00;
			rx_done_reg <= 1'b0;
		end else begin
			rx_done_reg <= 1'b0;
			if (ovs_tick_reg) begin
				rx_ovs_reg <= rx_ovs_reg + 4'h1;
				unique case (rxs_reg)
					hsfc_pkg::SER_IDLE: begin
						rx_ovs_reg <= 4'h0;
						if (!host_txd)
							rxs_reg <= hsfc_pkg::SER_START;
					end
					hsfc_pkg::SER_START: begin
						// A start bit shorter than half a bit is a glitch
						if (host_txd)
							rxs_reg <= hsfc_pkg::SER_IDLE;
						else if (rx_ovs_reg == 4'h7) begin
							rx_ovs_reg <= 4'h0;
							rx_bit_reg <= 3'h0;
							rxs_reg <= hsfc_pkg::SER_DATA;
						end
					end
					hsfc_pkg::SER_DATA: begin
						if (rx_ovs_reg == 4'hF) begin
							rx_sh_reg <= {host_txd, rx_sh_reg[7:1]};
							rx_bit_reg <= rx_bit_reg + 3'h1;
							if (rx_bit_reg == 3'h7)
								rxs_reg <= hsfc_pkg::SER_STOP;
						end
					end
					hsfc_pkg::SER_STOP: begin
						if (rx_ovs_reg == 4'hF) begin
							rx_done_reg <= host_txd; // RULE_19
							rxs_reg <= hsfc_pkg::SER_IDLE;
						end
					end
				endcase
			end
		end
	end

	assign is_stop = recog_en && rx_sh_reg == stop_chr_reg;
	assign is_start = recog_en && rx_sh_reg == start_chr_reg;

	// Recognised flow characters are consumed, not forwarded
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			rx_valid <= rx_done_reg && !is_stop && !is_start; // RULE_03
			if (rx_done_reg)
				rx_data <= rx_sh_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			halt_sw_reg <= 1'b0;
		else if (soft_reset || !recog_en)
			halt_sw_reg <= 1'b0; // RULE_03
		else if (rx_done_reg && is_stop)
			halt_sw_reg <= 1'b1; // RULE_01
		else if (rx_done_reg && is_start)
			halt_sw_reg <= 1'b0;
	end

	// ==========================================================
	// Fax sampling: fractional divider keeps instants evenly spaced
	logic [24:0] fax_acc_reg;
	logic [25:0] fax_sum;
	logic fax_tick_reg, fax_full_reg;
	logic [7:0] fax_sh_reg, fax_byte_reg;
	logic [2:0] fax_cnt_reg;
	logic fax_mode, take_fax;

	assign fax_mode = ctrl_reg[hsfc_pkg::B_FAX];
	assign fax_sum = {1'b0, fax_acc_reg} + {10'h000, fax_rate_reg};

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fax_acc_reg <= 25'h000_0000;
			fax_tick_reg <= 1'b0;
		end else if (!fax_mode || soft_reset) begin
			fax_acc_reg <= 25'h000_0000;
			fax_tick_reg <= 1'b0;
		end else if (fax_sum >= 26'(CLK_HZ)) begin
			fax_acc_reg <= 25'(fax_sum - 26'(CLK_HZ)); // RULE_22
			fax_tick_reg <= 1'b1;
		end else begin
			fax_acc_reg <= fax_sum[24:0];
			fax_tick_reg <= 1'b0;
		end
	end

	// An unsent byte is overwritten: the picture tolerates a lost line
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fax_sh_reg <= 8'h00;
			fax_byte_reg <= 8'h00;
			fax_cnt_reg <= 3'h0;
			fax_full_reg <= 1'b0;
		end else if (!fax_mode || soft_reset) begin
			fax_cnt_reg <= 3'h0;
			fax_full_reg <= 1'b0;
		end else begin
			if (take_fax)
				fax_full_reg <= 1'b0;
			if (fax_tick_reg) begin
				fax_sh_reg <= {fax_sh_reg[6:0], audio_sample >= fax_thr_reg};
				fax_cnt_reg <= fax_cnt_reg + 3'h1;
				if (fax_cnt_reg == 3'h7) begin
					fax_byte_reg <= {fax_sh_reg[6:0],
						audio_sample >= fax_thr_reg}; // RULE_14
					fax_full_reg <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Transmitter to host
	hsfc_pkg::hsfc_ser_t txs_reg;
	logic [3:0] tx_ovs_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] tx_sh_reg, hold_reg;
	logic tx_idle, flow_req, take_flow, take_hold;

	always_comb begin
		tx_idle = txs_reg == hsfc_pkg::SER_IDLE;
		flow_req = send_en && (rx_throttle != paused_reg);
		// Halt is only looked at between characters // RULE_21
		take_flow = tx_idle && host_rts && flow_req; // RULE_09
		take_fax = tx_idle && host_rts && !flow_req && !halt_sw_reg &&
			fax_mode && fax_full_reg;
		take_hold = tx_idle && host_rts && !flow_req && !halt_sw_reg &&
			!fax_mode && !tx_ready;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			paused_reg <= 1'b0;
		else if (soft_reset || !send_en)
			paused_reg <= 1'b0;
		else if (take_flow)
			paused_reg <= rx_throttle; // RULE_05 RULE_06
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tx_ready <= 1'b1;
			hold_reg <= 8'h00;
		end else if (tx_valid && tx_ready) begin
			tx_ready <= 1'b0;
			hold_reg <= tx_data;
		end else if (take_hold) begin
			tx_ready <= 1'b1;
		end
	end

	// Start bit may run up to one tick short; well inside 8N1 tolerance
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			txs_reg <= hsfc_pkg::SER_IDLE;
			tx_ovs_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_sh_reg <= 8'h00;
			host_rxd <= 1'b1;
		end else if (tx_idle) begin
			tx_ovs_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			if (take_flow || take_fax || take_hold) begin
				txs_reg <= hsfc_pkg::SER_START;
				host_rxd <= 1'b0;
			end
			if (take_flow)
				tx_sh_reg <= rx_throttle ? xoff_chr_reg : xon_chr_reg; // RULE_01
			else if (take_fax)
				tx_sh_reg <= fax_byte_reg;
			else if (take_hold)
				tx_sh_reg <= hold_reg;
		end else if (ovs_tick_reg) begin
			tx_ovs_reg <= tx_ovs_reg + 4'h1;
			if (tx_ovs_reg == 4'hF) begin
				unique case (txs_reg)
					hsfc_pkg::SER_START: begin
						txs_reg <= hsfc_pkg::SER_DATA;
						host_rxd <= tx_sh_reg[0];
					end
					hsfc_pkg::SER_DATA: begin
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg == 3'h7) begin
							txs_reg <= hsfc_pkg::SER_STOP;
							host_rxd <= 1'b1;
						end else begin
							host_rxd <= tx_sh_reg[tx_bit_reg + 3'h1];
						end
					end
					hsfc_pkg::SER_STOP: txs_reg <= hsfc_pkg::SER_IDLE;
					hsfc_pkg::SER_IDLE: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Status lines and mode outputs
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			host_cts <= 1'b0;
			host_dsr <= 1'b1;
			host_dcd <= 1'b0;
			radio_key <= 1'b0;
			xkf_checksum_on <= 1'b0;
			xkf_polled_on <= 1'b0;
		end else begin
			host_cts <= send_en || !rx_throttle; // RULE_10
			host_dsr <= 1'b1; // RULE_11
			host_dcd <= link_connected; // RULE_12
			radio_key <= radio_key_req && ctrl_reg[hsfc_pkg::B_PERMIT]; // RULE_08
			xkf_checksum_on <= ctrl_reg[hsfc_pkg::B_XKF] &&
				ctrl_reg[hsfc_pkg::B_CHKSUM]; // RULE_15
			xkf_polled_on <= ctrl_reg[hsfc_pkg::B_XKF] &&
				ctrl_reg[hsfc_pkg::B_POLLED]; // RULE_16
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_n);

	rts_gate_a: assert property (tx_idle ##1 !tx_idle // RULE_09
		|-> $past(host_rts)) else $error("character started without RTS");
	stop_halt_a: assert property (rx_done_reg && is_stop && !soft_reset // RULE_01
		|=> halt_sw_reg) else $error("stop character did not halt output");
	halt_hold_a: assert property (halt_sw_reg && tx_idle && !flow_req // RULE_21
		|=> tx_idle) else $error("halted output started a data character");
	xflow_off_a: assert property (!recog_en |=> !halt_sw_reg) // RULE_03
		else $error("halt kept without software flow");
	zero_char_a: assert property ((xoff_chr_reg == 8'h00) |-> !send_en) // RULE_04
		else $error("pause sending active with zero character");
	pause_send_a: assert property (take_flow && rx_throttle // RULE_05
		|=> tx_sh_reg == $past(xoff_chr_reg) && paused_reg)
		else $error("pause character not loaded");
	resume_send_a: assert property (take_flow && !rx_throttle // RULE_06
		|=> tx_sh_reg == $past(xon_chr_reg) && !paused_reg)
		else $error("resume character not loaded");
	cts_hw_a: assert property (!send_en && rx_throttle |=> !host_cts) // RULE_20
		else $error("CTS not dropped in hardware mode");
	tx_inhibit_a: assert property (!ctrl_reg[hsfc_pkg::B_PERMIT] // RULE_08
		|=> !radio_key) else $error("radio keyed while inhibited");
	dcd_follow_a: assert property (host_dcd == $past(link_connected)) // RULE_12
		else $error("DCD does not follow link state");
	level_max_a: assert property (drive_level_code <= hsfc_pkg::LEVEL_MAX && // RULE_17
		drive_coarse == (drive_level_code > hsfc_pkg::LEVEL_FINE_MAX))
		else $error("drive code out of range");
	ext_reset_a: assert property ($fell(ext_s2_reg) && // RULE_18
		ctrl_reg[hsfc_pkg::B_EXTRST] |=> soft_reset)
		else $error("external pull did not reset");
	fax_byte_a: assert property (fax_mode && !soft_reset && fax_tick_reg && // RULE_14
		fax_cnt_reg == 3'h7 |=> fax_full_reg)
		else $error("eighth fax sample gave no byte");

endmodule : hsfc_top

`default_nettype wire

/* File: test/hsfc_host_model.sv */
// Host end of the serial link: an 8N1 terminal that logs what it receives.
// Assumes one bit lasts BIT core clocks at the baud rate chosen by the bench.
`timescale 1ns/10ps
`default_nettype none
module hsfc_host_model #(
	parameter int BIT = 16
) (
	input wire logic core_clk,
	input wire logic host_rxd,
	output logic host_txd
);
	logic [7:0] got [$];
	logic [7:0] sh;
	initial host_txd = 1'b1;
	// ==========================================================
	// Receiver: sample mid-bit, LSB first; bad stop bit drops the byte
	always begin
		@(negedge host_rxd);
		repeat (BIT / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge core_clk);
			sh[i] = host_rxd;
		end
		repeat (BIT) @(posedge core_clk);
		if (host_rxd === 1'b1) got.push_back(sh);
	end
	// ==========================================================
	// Sender: idle high between frames so no false start appears
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			host_txd <= f[i];
			repeat (BIT) @(posedge core_clk);
		end
	endtask : send
endmodule : hsfc_host_model
`default_nettype wire

/* File: test/hsfc_tb_top.sv */
// Self-checking bench for hsfc_top: register calls, link traffic, checks.
// Assumes CLK_HZ 153600 so one 9600 baud bit is 16 core clocks.
`timescale 1ns/10ps
`default_nettype none
module hsfc_tb_top;
	logic core_clk, rst_n, reg_wr, reg_rd, host_rts, host_dtr, tx_valid;
	logic rx_throttle, link_connected, radio_key_req, external_input_pin;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic [7:0] tx_data, rx_data, audio_sample, rxq [$];
	logic host_txd, host_rxd, host_cts, host_dsr, host_dcd, tx_ready, rx_valid;
	logic radio_key, drive_coarse, xkf_checksum_on, xkf_polled_on, soft_reset;
	logic [8:0] drive_level_code;
	int mismatches, cmp_count, cycles, pulses;
	logic [15:0] rst_tab [9] = '{16'h0011, 16'h0011, 16'h0013, 16'h0011,
		16'h0013, 16'h0005, 16'h0078, 16'h0064, 16'h0080};

	hsfc_top #(.CLK_HZ(153600)) u_hsfc_top (.core_clk(core_clk),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.host_txd(host_txd), .host_rxd(host_rxd), .host_rts(host_rts),
		.host_cts(host_cts), .host_dsr(host_dsr), .host_dcd(host_dcd),
		.host_dtr(host_dtr), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_throttle(rx_throttle), .link_connected(link_connected),
		.audio_sample(audio_sample), .radio_key_req(radio_key_req),
		.radio_key(radio_key), .drive_level_code(drive_level_code),
		.drive_coarse(drive_coarse), .xkf_checksum_on(xkf_checksum_on),
		.xkf_polled_on(xkf_polled_on),
		.external_input_pin(external_input_pin), .soft_reset(soft_reset));
	hsfc_host_model #(.BIT(16)) u_hsfc_host_model (.core_clk(core_clk),
		.host_rxd(host_rxd), .host_txd(host_txd));

	// ==========================================================
	// Clock, hang guard, capture of bytes handed to the core
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (rx_valid === 1'b1) rxq.push_back(rx_data);
		if (cycles == 60000) begin
			mismatches++;
			end_sim();
		end
	end

	// ==========================================================
	// Access tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		v = reg_rdata;
	endtask : rd
	task automatic put(input logic [7:0] b);
		@(posedge core_clk);
		for (int i = 0; i < 400 && tx_ready !== 1'b1; i++) @(posedge core_clk);
		tx_data <= b;
		tx_valid <= 1'b1;
		@(posedge core_clk);
		tx_valid <= 1'b0;
	endtask : put
	// Waits bounded: a silent design must not stall the run
	task automatic wait_got(input int n);
		for (int i = 0; i < 400 && u_hsfc_host_model.got.size() < n; i++)
			@(posedge core_clk);
	endtask : wait_got
	task automatic flush();
		repeat (200) @(posedge core_clk);
		u_hsfc_host_model.got.delete();
		rxq.delete();
	endtask : flush
	task automatic end_sim();
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// ==========================================================
	// Main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, tx_valid, rx_throttle, link_connected} = '0;
		{reg_addr, reg_wdata, tx_data, radio_key_req} = '0;
		audio_sample = 8'h7F;
		{host_rts, host_dtr, external_input_pin} = 3'b111;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(host_dsr, 1'b1);
		for (int a = 0; a < 9; a++) begin
			rd(a[3:0]);
			chk(v, rst_tab[a]);
		end
		rd(4'hA);
		chk(v, 16'h0000);
		chk(drive_level_code, 9'h064);
		link_connected <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(host_dcd, 1'b1);
		link_connected <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(host_dcd, 1'b0);
		// Pause then resume; DTR low meanwhile must change nothing
		host_dtr <= 1'b0;
		rx_throttle <= 1'b1;
		wait_got(1);
		chk(u_hsfc_host_model.got.pop_front(), 8'h13);
		chk(host_cts, 1'b1);
		rx_throttle <= 1'b0;
		wait_got(1);
		chk(u_hsfc_host_model.got.pop_front(), 8'h11);
		// Zero pause character: only CTS throttles
		wr(hsfc_pkg::A_XOFF, 16'h0000);
		rx_throttle <= 1'b1;
		flush();
		chk(host_cts, 1'b0);
		rx_throttle <= 1'b0;
		wr(hsfc_pkg::A_XOFF, 16'h0013);
		flush();
		// Stop character halts output until start arrives
		u_hsfc_host_model.send(8'h13);
		put(8'h5A);
		repeat (300) @(posedge core_clk);
		chk(u_hsfc_host_model.got.size(), 16'h0000);
		chk(tx_ready, 1'b0);
		rd(hsfc_pkg::A_STATUS);
		chk(v, 16'h00E7);
		u_hsfc_host_model.send(8'h11);
		wait_got(1);
		chk(u_hsfc_host_model.got.pop_front(), 8'h5A);
		chk(rxq.size(), 16'h0000);
		// RTS low withholds output
		host_rts <= 1'b0;
		put(8'hC3);
		repeat (300) @(posedge core_clk);
		chk(u_hsfc_host_model.got.size(), 16'h0000);
		host_rts <= 1'b1;
		wait_got(1);
		chk(u_hsfc_host_model.got.pop_front(), 8'hC3);
		// Software flow off: stop character is plain data
		wr(hsfc_pkg::A_CTRL, 16'h0010);
		u_hsfc_host_model.send(8'h13);
		repeat (40) @(posedge core_clk);
		chk(rxq.pop_front(), 8'h13);
		// Transparent without transmit flow: throttle by CTS only
		wr(hsfc_pkg::A_CTRL, 16'h0013);
		rx_throttle <= 1'b1;
		repeat (300) @(posedge core_clk);
		chk(u_hsfc_host_model.got.size(), 16'h0000);
		chk(host_cts, 1'b0);
		rx_throttle <= 1'b0;
		wr(hsfc_pkg::A_CTRL, 16'h0011);
		flush();
		// Transmit permit gates keying
		radio_key_req <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(radio_key, 1'b1);
		wr(hsfc_pkg::A_CTRL, 16'h0001);
		repeat (3) @(posedge core_clk);
		chk(radio_key, 1'b0);
		// Drive level clamp and step size
		wr(hsfc_pkg::A_LEVEL, 16'h01F7);
		rd(hsfc_pkg::A_LEVEL);
		chk(v, 16'h01F6);
		chk(drive_coarse, 1'b1);
		wr(hsfc_pkg::A_LEVEL, 16'h00FF);
		repeat (2) @(posedge core_clk);
		chk(drive_coarse, 1'b0);
		// Keyed framing options only with the framing mode on
		wr(hsfc_pkg::A_CTRL, 16'h00D1);
		repeat (2) @(posedge core_clk);
		chk({xkf_checksum_on, xkf_polled_on}, 2'b00);
		wr(hsfc_pkg::A_CTRL, 16'h00F1);
		repeat (2) @(posedge core_clk);
		chk({xkf_checksum_on, xkf_polled_on}, 2'b11);
		// External pin soft reset, enabled then disabled
		for (int e = 1; e >= 0; e--) begin
			wr(hsfc_pkg::A_CTRL, e ? 16'h0211 : 16'h0011);
			pulses = 0;
			external_input_pin <= 1'b0;
			@(posedge core_clk);
			external_input_pin <= 1'b1;
			repeat (10) begin
				@(posedge core_clk);
				pulses += (soft_reset === 1'b1);
			end
			chk(pulses, e);
		end
		// Fax bits: just below threshold gives zeros, at threshold ones
		wr(hsfc_pkg::A_FAXRATE, 16'h04B0);
		wr(hsfc_pkg::A_CTRL, 16'h0111);
		for (int i = 0; i < 8; i++) wait_got(1);
		chk(u_hsfc_host_model.got.pop_front(), 8'h00);
		audio_sample <= 8'h80;
		// The byte in progress mixes both levels; only the next is judged
		for (int i = 0; i < 8; i++) wait_got(2);
		void'(u_hsfc_host_model.got.pop_front());
		chk(u_hsfc_host_model.got.pop_front(), 8'hFF);
		end_sim();
	end
endmodule : hsfc_tb_top
`default_nettype wire
